// ### testbench/reset_init_sequencer_tb.sv
// Purpose: Self-checking bench for the reset and init sequencer.
// Assumes: Clock enable held high throughout.
// Notes: Gear 0 is written to shorten tick spacing checks.
`timescale 1ns/1ps
`default_nettype none
module reset_init_sequencer_tb;
   import ris_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_n_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rst_pin_n_i, stop_mode_i, vec_rd_o, vec_ack_i;
   logic cpu_start_o, cpu_run_o, periph_init_o, port_gpio_force_o, fph_tick_o, sys_tick_o;
   logic ale_o, ale_oe_o, wake_o, wake_oe_o, wide_mode_o;
   logic [1:0] operating_mode_straps_i;
   logic [2:0] interrupt_mask_level_o, register_bank_pointer_o, gear_sel_o;
   logic [3:0] wb_sel_i, lat;
   logic [7:0] wb_adr_i, vec_data_i;
   logic [23:0] vec_addr_o, pc_o, vword;
   logic [31:0] wb_dat_i, wb_dat_o, extended_stack_pointer_o, q;
   int err_total = 0;
   int n_checks = 0;
   int n;
   always #5 ref_clk_i = ~ref_clk_i;
   ris_sequencer uut (.ref_clk_i, .reset_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .rst_pin_n_i, .operating_mode_straps_i, .stop_mode_i, .vec_addr_o,
      .vec_rd_o, .vec_ack_i, .vec_data_i, .pc_o, .extended_stack_pointer_o, .interrupt_mask_level_o,
      .wide_mode_o, .register_bank_pointer_o, .cpu_start_o, .cpu_run_o, .periph_init_o, .port_gpio_force_o,
      .gear_sel_o, .fph_tick_o, .sys_tick_o, .ale_o, .ale_oe_o, .wake_o, .wake_oe_o);
   ris_vec_mem_model u_mem (.clk_i(ref_clk_i), .rst_n_i(reset_n_i), .vec_addr_i(vec_addr_o), .vec_rd_i(vec_rd_o),
      .vec_word_i(vword), .lat_i(lat), .vec_ack_o(vec_ack_i), .vec_data_o(vec_data_i));
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Holds the request until ack is sampled, then idles one cycle.
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int i;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge ref_clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk_i);
      if (i >= 50) begin
         err_total++;
         end_of_test;
      end
   endtask
   task automatic wait_start;
      int i;
      for (i = 0; i < 1000 && cpu_start_o !== 1'b1; i++)
         @(posedge ref_clk_i);
      if (i >= 1000) begin
         err_total++;
         end_of_test;
      end
   endtask
   task automatic gap;
      int i;
      for (i = 0; i < 100 && sys_tick_o !== 1'b1; i++)
         @(posedge ref_clk_i);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (sys_tick_o !== 1'b1 && n < 100);
   endtask
   initial begin
      reset_n_i <= 1'b0;
      ce_i <= 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, stop_mode_i} <= 4'h0;
      wb_sel_i <= 4'hF;
      wb_adr_i <= 8'h00;
      wb_dat_i <= 32'h00000000;
      rst_pin_n_i <= 1'b1;
      operating_mode_straps_i <= RIS_STRAPS_REQ;
      vword <= 24'h3A5C7E;
      lat <= 4'h3;
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      wait_start;
      chk(pc_o, 32'h3A5C7E);
      chk(gear_sel_o, RIS_GEAR_RESET);
      wb(1'b0, RIS_OFS_FLAGS, 32'h0);
      chk(q, 32'h000000F0);
      wb(1'b0, RIS_OFS_STACK, 32'h0);
      chk(q, RIS_STACK_RESET);
      chk({cpu_run_o, ale_oe_o, port_gpio_force_o, wake_oe_o, wake_o}, 5'b10010);
      gap;
      chk(n, 32);
      wb(1'b1, RIS_OFS_CTRL, 32'h00000008);
      wb(1'b1, RIS_OFS_CTRL, 32'h0000000D);
      wb(1'b0, RIS_OFS_CTRL, 32'h0);
      chk(q[3:0], 4'h8);
      chk({ale_oe_o, ale_o}, 2'b11);
      gap;
      chk(n, 2);
      wb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      stop_mode_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      chk(wake_oe_o, 1'b0);
      wb(1'b0, RIS_OFS_STATUS, 32'h0);
      chk(q, 32'h00000090);
      stop_mode_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk({wake_oe_o, wake_o}, 2'b10);
      // A short low must stop the core but not start a new fetch.
      rst_pin_n_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rst_pin_n_i <= 1'b1;
      repeat (60) @(posedge ref_clk_i);
      chk({cpu_run_o, vec_rd_o, port_gpio_force_o, ale_oe_o}, 4'b0010);
      vword <= 24'hC4B2A1;
      lat <= 4'h0;
      rst_pin_n_i <= 1'b0;
      repeat (340) @(posedge ref_clk_i);
      rst_pin_n_i <= 1'b1;
      wait_start;
      chk(pc_o, 32'hC4B2A1);
      chk(gear_sel_o, RIS_GEAR_RESET);
      wb(1'b0, RIS_OFS_STATUS, 32'h0);
      chk(q, 32'h00000088);
      end_of_test;
   end
endmodule
`default_nettype wire

// ### testbench/ris_seq_assertions.sv
// Purpose: Port-level checks of the reset and init sequencer.
// Assumes: One clock domain; reset_n_i low clears all state.
// Notes: Bound to every ris_sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module ris_seq_assertions
   import ris_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic rst_pin_n_i,
   input wire logic [23:0] vec_addr_o,
   input wire logic vec_rd_o,
   input wire logic vec_ack_i,
   input wire logic [7:0] vec_data_i,
   input wire logic [23:0] pc_o,
   input wire logic [31:0] extended_stack_pointer_o,
   input wire logic [2:0] interrupt_mask_level_o,
   input wire logic wide_mode_o,
   input wire logic [2:0] register_bank_pointer_o,
   input wire logic cpu_start_o,
   input wire logic cpu_run_o,
   input wire logic periph_init_o,
   input wire logic port_gpio_force_o,
   input wire logic [2:0] gear_sel_o,
   input wire logic ale_oe_o,
   input wire logic wake_oe_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // A pin reset may abort a fetch, so only bytes taken with the pin high count.
   sequence s_byte_taken;
      vec_rd_o && vec_ack_i && rst_pin_n_i;
   endsequence
   sequence s_flags_preset;
      interrupt_mask_level_o == RIS_MASK_RESET && wide_mode_o == RIS_WIDE_RESET
         && register_bank_pointer_o == RIS_BANK_RESET;
   endsequence
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   a_gear_reset: assert property ($rose(reset_n_i) |-> gear_sel_o == RIS_GEAR_RESET)
      else $error("gear select not divide by 16 after reset");
   a_xsp_start: assert property (cpu_start_o |-> extended_stack_pointer_o == RIS_STACK_RESET)
      else $error("stack pointer wrong at start");
   a_flags_start: assert property (cpu_start_o |-> s_flags_preset)
      else $error("flag word wrong at start");
   a_vec_hold: assert property (vec_rd_o && !vec_ack_i && rst_pin_n_i |=> vec_rd_o && $stable(vec_addr_o))
      else $error("vector request dropped before ack");
   a_vec_step: assert property (s_byte_taken |=> !vec_rd_o && vec_addr_o == $past(vec_addr_o) + 24'h1)
      else $error("vector address did not step");
   a_pc_low: assert property (s_byte_taken ##0 vec_addr_o[1:0] == 2'h0 |=> pc_o[7:0] == $past(vec_data_i))
      else $error("low pc byte not loaded");
   a_pin_hold: assert property (!rst_pin_n_i |=> !cpu_run_o)
      else $error("cpu runs while reset pin low");
   a_ale_float: assert property (periph_init_o |-> !ale_oe_o)
      else $error("address strobe driven in reset");
   a_wake_float: assert property (periph_init_o |-> !wake_oe_o)
      else $error("stop monitor driven in reset");
   a_gpio_reset: assert property ($rose(reset_n_i) |-> port_gpio_force_o && periph_init_o)
      else $error("ports or peripherals not in reset state");
endmodule
bind ris_sequencer ris_seq_assertions u_chk (.ref_clk_i, .reset_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .rst_pin_n_i, .vec_addr_o, .vec_rd_o, .vec_ack_i, .vec_data_i, .pc_o, .extended_stack_pointer_o,
   .interrupt_mask_level_o, .wide_mode_o, .register_bank_pointer_o, .cpu_start_o, .cpu_run_o,
   .periph_init_o, .port_gpio_force_o, .gear_sel_o, .ale_oe_o, .wake_oe_o);
`default_nettype wire

// ### testbench/ris_vec_mem_model.sv
// Purpose: Vector memory answering the sequencer's byte reads.
// Assumes: Requests are held until acknowledged.
// Notes: Data outside an ack toggles so stale bytes never match.
`timescale 1ns/1ps
`default_nettype none
module ris_vec_mem_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [23:0] vec_addr_i,
   input wire logic vec_rd_i,
   input wire logic [23:0] vec_word_i,
   input wire logic [3:0] lat_i,
   output logic vec_ack_o,
   output logic [7:0] vec_data_o
);
   logic [3:0] wait_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_ff <= 4'h0;
         vec_ack_o <= 1'b0;
         vec_data_o <= 8'h00;
      end else if (vec_rd_i && !vec_ack_o && wait_ff >= lat_i) begin
         wait_ff <= 4'h0;
         vec_ack_o <= 1'b1;
         vec_data_o <= vec_word_i[8*vec_addr_i[1:0] +: 8];
      end else begin
         wait_ff <= (vec_rd_i && !vec_ack_o) ? wait_ff + 4'h1 : 4'h0;
         vec_ack_o <= 1'b0;
         vec_data_o <= ~vec_data_o;
      end
   end
endmodule
`default_nettype wire

// ### verilog/ris_clk_gear.sv
// Purpose: Derives geared and system clock enables from the reference clock.
// Assumes: gear_sel never above the divide-by-16 code.
// Notes: Ticks are enables, not clocks, so the design stays one domain.
`timescale 1ns/1ps
`default_nettype none
module ris_clk_gear
   import ris_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   ris_gear_if.src gear
);
   logic [3:0] div_cnt_ff;
   logic [3:0] nxt_div_cnt;
   logic [3:0] div_mask;
   logic half_ff;
   logic fph_ff;
   logic sys_ff;
   logic fph_hit;

   // Gear n divides the reference by two to the power n.
   assign div_mask = 4'hF << gear.gear_sel;
   assign fph_hit = ((div_cnt_ff & ~div_mask) == ~div_mask) || (gear.gear_sel == 3'h0);
   assign nxt_div_cnt = fph_hit ? 4'h0 : div_cnt_ff + 4'h1;
   assign gear.fph_tick = fph_ff;
   assign gear.sys_tick = sys_ff;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_ff <= 4'h0;
         half_ff <= 1'b0;
         fph_ff <= 1'b0;
         sys_ff <= 1'b0;
      end else if (ce_i) begin
         div_cnt_ff <= nxt_div_cnt;
         fph_ff <= fph_hit;
         if (fph_hit) begin
            half_ff <= ~half_ff;
         end
         sys_ff <= fph_hit && half_ff;
      end
   end
endmodule
`default_nettype wire

// ### verilog/ris_gear_if.sv
// Purpose: Carries gear select and derived clock ticks between modules.
// Assumes: Single clock domain; ticks are one-cycle enables.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface ris_gear_if;
   logic [2:0] gear_sel;
   logic fph_tick;
   logic sys_tick;
   modport src (input gear_sel, output fph_tick, output sys_tick);
   modport snk (output gear_sel, input fph_tick, input sys_tick);
endinterface
`default_nettype wire

// ### verilog/ris_pkg.sv
// Purpose: Shared constants for the reset and init sequencer.
// Assumes: 100 MHz reference clock, classic Wishbone register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package ris_pkg;
   localparam logic [7:0] RIS_OFS_CTRL = 8'h00;
   localparam logic [7:0] RIS_OFS_STATUS = 8'h04;
   localparam logic [7:0] RIS_OFS_PC = 8'h08;
   localparam logic [7:0] RIS_OFS_FLAGS = 8'h0C;
   localparam logic [7:0] RIS_OFS_STACK = 8'h10;
   localparam int RIS_CTRL_GEAR_LSB = 0;
   localparam int RIS_CTRL_ALE_EN_BIT = 3;
   localparam int RIS_GEAR_W = 3;
   localparam logic [2:0] RIS_GEAR_RESET = 3'h4;
   localparam logic [2:0] RIS_GEAR_MAX = 3'h4;
   localparam logic [23:0] RIS_VEC_ADDR0 = 24'hFFFF00;
   localparam logic [31:0] RIS_STACK_RESET = 32'h00000100;
   localparam logic [2:0] RIS_MASK_RESET = 3'h7;
   localparam logic RIS_WIDE_RESET = 1'b1;
   localparam logic [2:0] RIS_BANK_RESET = 3'h0;
   localparam logic [1:0] RIS_STRAPS_REQ = 2'h3;
   localparam int RIS_RST_MIN_SYS = 10;
   typedef enum logic [4:0] {
      RIS_ST_HOLD = 5'b00001,
      RIS_ST_FETCH = 5'b00010,
      RIS_ST_WAIT = 5'b00100,
      RIS_ST_RUN = 5'b01000,
      RIS_ST_STOP = 5'b10000
   } ris_state_type;
endpackage

// ### verilog/ris_sequencer.sv
// Purpose: Reset filter and post-reset initialisation sequencer with Wishbone registers.
// Assumes: Reset pin and vector port are synchronous to ref_clk_i.
// Notes: CPU state outputs stand for the core to load at cpu_start_o.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reset selects divide-by-16 gear, system oscillator/32.
// - Load PC bytes from three vector addresses.
// - Reset presets extended stack pointer to 100h.
// - Reset sets interrupt mask level to seven.
// - Reset sets wide addressing flag to one.
// - Reset clears register bank pointer to zero.
// - Start fetch at loaded PC, others untouched.
// - Reset returns peripheral registers to defaults.
// - Reset makes all port pins plain GPIO.
// - Reset floats the address latch strobe.
// - Reset leaves on-chip RAM contents alone.
// - Stop monitor low running, floating otherwise.
// - System clock is geared clock halved.
// - Reset loads gear select with binary 100.
module ris_sequencer
   import ris_pkg::*;
#(
   parameter int RST_MIN_SYS = RIS_RST_MIN_SYS
)
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rst_pin_n_i,
   input wire logic [1:0] operating_mode_straps_i,
   input wire logic stop_mode_i,
   output logic [23:0] vec_addr_o,
   output logic vec_rd_o,
   input wire logic vec_ack_i,
   input wire logic [7:0] vec_data_i,
   output logic [23:0] pc_o,
   output logic [31:0] extended_stack_pointer_o,
   output logic [2:0] interrupt_mask_level_o,
   output logic wide_mode_o,
   output logic [2:0] register_bank_pointer_o,
   output logic cpu_start_o,
   output logic cpu_run_o,
   output logic periph_init_o,
   output logic port_gpio_force_o,
   output logic [2:0] gear_sel_o,
   output logic fph_tick_o,
   output logic sys_tick_o,
   output logic ale_o,
   output logic ale_oe_o,
   output logic wake_o,
   output logic wake_oe_o
);
   import ris_pkg::*;

   ris_gear_if gear_bus ();

   ris_state_type state_ff;
   ris_state_type nxt_state;
   logic [7:0] low_cnt_ff;
   logic [7:0] nxt_low_cnt;
   logic low_ok_ff;
   logic [1:0] byte_idx_ff;
   logic [2:0] gear_ff;
   logic ale_en_ff;
   logic straps_ok_ff;
   logic [23:0] pc_ff;
   logic [2:0] mask_ff;
   logic wide_ff;
   logic [2:0] bank_ff;
   logic [31:0] stack_ff;
   logic start_ff;
   logic init_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [23:0] vaddr_ff;
   logic vrd_ff;
   logic ale_ff;
   logic ale_oe_ff;
   logic wake_oe_ff;
   logic fph_ff;
   logic sys_ff;
   logic run_ff;

   logic pin_low;
   logic reset_taken;
   logic wb_req;
   logic wb_wr;
   logic hit_ctrl;
   logic hit_status;
   logic hit_pc;
   logic hit_flags;
   logic hit_stack;
   logic [31:0] rd_mux;
   logic gear_wr;
   logic [2:0] wr_gear;
   logic last_byte;

   ris_clk_gear u_gear (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .gear(gear_bus.src)
   );

   assign gear_bus.gear_sel = gear_ff;

   // Reset pin filter. A low pulse shorter than the minimum stops the core but does not release a new fetch.
   assign pin_low = !rst_pin_n_i;
   assign nxt_low_cnt = (low_cnt_ff == 8'hFF) ? low_cnt_ff : low_cnt_ff + 8'h01;
   assign reset_taken = rst_pin_n_i && low_ok_ff;
   assign last_byte = (byte_idx_ff == 2'h2);

   // Wishbone decode.
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_wr = wb_req && wb_we_i;
   assign hit_ctrl = (wb_adr_i == RIS_OFS_CTRL);
   assign hit_status = (wb_adr_i == RIS_OFS_STATUS);
   assign hit_pc = (wb_adr_i == RIS_OFS_PC);
   assign hit_flags = (wb_adr_i == RIS_OFS_FLAGS);
   assign hit_stack = (wb_adr_i == RIS_OFS_STACK);
   assign wr_gear = wb_dat_i[RIS_CTRL_GEAR_LSB +: RIS_GEAR_W];
   // Reserved gear codes are ignored so the divider never sees them.
   assign gear_wr = wb_wr && hit_ctrl && wb_sel_i[0] && (wr_gear <= RIS_GEAR_MAX) && (state_ff == RIS_ST_RUN);
   assign rd_mux = hit_ctrl ? {28'h0000000, ale_en_ff, gear_ff} :
                   hit_status ? {24'h000000, straps_ok_ff, 2'h0, state_ff} :
                   hit_pc ? {8'h00, pc_ff} :
                   hit_flags ? {24'h000000, wide_ff, mask_ff, 1'b0, bank_ff} :
                   hit_stack ? stack_ff : 32'h00000000;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         RIS_ST_HOLD: begin
            if (reset_taken) begin
               nxt_state = RIS_ST_FETCH;
            end
         end
         RIS_ST_FETCH: begin
            nxt_state = RIS_ST_WAIT;
         end
         RIS_ST_WAIT: begin
            if (vec_ack_i) begin
               nxt_state = last_byte ? RIS_ST_RUN : RIS_ST_FETCH;
            end
         end
         RIS_ST_RUN: begin
            if (stop_mode_i) begin
               nxt_state = RIS_ST_STOP;
            end
         end
         RIS_ST_STOP: begin
            if (!stop_mode_i) begin
               nxt_state = RIS_ST_RUN;
            end
         end
      endcase
      if (pin_low) begin
         nxt_state = RIS_ST_HOLD;
      end
   end

   // Filter counts system clock periods of a continuous low level.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         low_cnt_ff <= 8'h00;
         low_ok_ff <= 1'b1;
      end else if (ce_i) begin
         if (!pin_low) begin
            low_cnt_ff <= 8'h00;
            if (state_ff != RIS_ST_HOLD) begin
               low_ok_ff <= 1'b0;
            end
         end else if (sys_ff) begin
            low_cnt_ff <= nxt_low_cnt;
            if (nxt_low_cnt >= 8'(RST_MIN_SYS)) begin
               low_ok_ff <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= RIS_ST_HOLD;
      end else if (ce_i) begin
         state_ff <= nxt_state;
      end
   end

   // Vector fetch. Only reads are issued, so on-chip RAM is never written.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte_idx_ff <= 2'h0;
         vaddr_ff <= RIS_VEC_ADDR0;
         vrd_ff <= 1'b0;
         pc_ff <= 24'h000000;
      end else if (ce_i) begin
         if (state_ff == RIS_ST_HOLD) begin
            byte_idx_ff <= 2'h0;
            vaddr_ff <= RIS_VEC_ADDR0;
            vrd_ff <= 1'b0;
         end else if (state_ff == RIS_ST_FETCH) begin
            vrd_ff <= 1'b1;
         end else if ((state_ff == RIS_ST_WAIT) && vec_ack_i) begin
            vrd_ff <= 1'b0;
            pc_ff[8 * byte_idx_ff +: 8] <= vec_data_i;
            byte_idx_ff <= byte_idx_ff + 2'h1;
            vaddr_ff <= vaddr_ff + 24'h000001;
         end
      end
   end

   // CPU state preset while the sequencer is in the hold state.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stack_ff <= RIS_STACK_RESET;
         mask_ff <= RIS_MASK_RESET;
         wide_ff <= RIS_WIDE_RESET;
         bank_ff <= RIS_BANK_RESET;
      end else if (ce_i && (state_ff == RIS_ST_HOLD)) begin
         stack_ff <= RIS_STACK_RESET;
         mask_ff <= RIS_MASK_RESET;
         wide_ff <= RIS_WIDE_RESET;
         bank_ff <= RIS_BANK_RESET;
      end
   end

   // Control registers and one-shot notifications.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gear_ff <= RIS_GEAR_RESET;
         ale_en_ff <= 1'b0;
         straps_ok_ff <= 1'b0;
         start_ff <= 1'b0;
         init_ff <= 1'b1;
      end else if (ce_i) begin
         start_ff <= (state_ff == RIS_ST_WAIT) && vec_ack_i && last_byte;
         if (state_ff == RIS_ST_HOLD) begin
            gear_ff <= RIS_GEAR_RESET;
            ale_en_ff <= 1'b0;
            init_ff <= 1'b1;
         end else begin
            init_ff <= 1'b0;
            if (gear_wr) begin
               gear_ff <= wr_gear;
            end
            if (wb_wr && hit_ctrl && wb_sel_i[0] && (state_ff == RIS_ST_RUN)) begin
               ale_en_ff <= wb_dat_i[RIS_CTRL_ALE_EN_BIT];
            end
         end
         // Straps are caught when the filtered reset is released.
         if ((state_ff == RIS_ST_HOLD) && reset_taken) begin
            straps_ok_ff <= (operating_mode_straps_i == RIS_STRAPS_REQ);
         end
      end
   end

   // Wishbone answer one cycle after the request, dropped the cycle after.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else if (ce_i) begin
         ack_ff <= wb_req;
         if (wb_req) begin
            rdata_ff <= wb_we_i ? 32'h00000000 : rd_mux;
         end
      end
   end

   // Pin drivers and registered clock ticks.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ale_ff <= 1'b0;
         ale_oe_ff <= 1'b0;
         wake_oe_ff <= 1'b0;
         fph_ff <= 1'b0;
         sys_ff <= 1'b0;
         run_ff <= 1'b0;
      end else if (ce_i) begin
         fph_ff <= gear_bus.fph_tick;
         sys_ff <= gear_bus.sys_tick;
         ale_oe_ff <= ale_en_ff && (nxt_state == RIS_ST_RUN);
         ale_ff <= ale_en_ff && (nxt_state == RIS_ST_RUN) && gear_bus.fph_tick;
         wake_oe_ff <= (nxt_state == RIS_ST_RUN);
         run_ff <= (nxt_state == RIS_ST_RUN);
      end
   end

   assign wb_dat_o = rdata_ff;
   assign wb_ack_o = ack_ff;
   assign vec_addr_o = vaddr_ff;
   assign vec_rd_o = vrd_ff;
   assign pc_o = pc_ff;
   assign extended_stack_pointer_o = stack_ff;
   assign interrupt_mask_level_o = mask_ff;
   assign wide_mode_o = wide_ff;
   assign register_bank_pointer_o = bank_ff;
   assign cpu_start_o = start_ff;
   assign cpu_run_o = run_ff;
   assign periph_init_o = init_ff;
   assign port_gpio_force_o = init_ff;
   assign gear_sel_o = gear_ff;
   assign fph_tick_o = fph_ff;
   assign sys_tick_o = sys_ff;
   assign ale_o = ale_ff;
   assign ale_oe_o = ale_oe_ff;
   // Low level whenever enabled; the enable alone floats the pin.
   assign wake_o = 1'b0;
   assign wake_oe_o = wake_oe_ff;
endmodule
`default_nettype wire
